//--- kps_pkg.sv
// shared constants and state type for the keypad matrix scanner
package kps_pkg;
	// ----------------------------------------------------------------
	// matrix geometry
	// ----------------------------------------------------------------
	localparam int          KPS_NUM_COLS      = 5;
	localparam int          KPS_NUM_ROWS      = 6;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [4:0]  KPS_COL_RESET     = 5'h1f;
	localparam logic [5:0]  KPS_ROW_RESET     = 6'h3f;
	localparam logic [2:0]  KPS_ORDER_RESET   = 3'h0;
	// ----------------------------------------------------------------
	// field layout of order and size words
	// ----------------------------------------------------------------
	localparam int          KPS_SLOT_W        = 3;
	localparam int          KPS_SIZE_COLS_LSB = 0;
	localparam int          KPS_SIZE_ROWS_LSB = 4;
	// ----------------------------------------------------------------
	// timing, in 1 ms ticks; the debounce zero value counts 4 ms units
	// ----------------------------------------------------------------
	localparam logic [8:0]  KPS_DB_STEP_MS    = 9'h004;
	localparam logic [8:0]  KPS_DB_ZERO_UNITS = 9'h040;
	localparam logic [8:0]  KPS_SCAN_ZERO_MS  = 9'h004;
	// ----------------------------------------------------------------
	// scanner states, gray along idle-debounce-scan-release
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		KPS_IDLE     = 3'b000,
		KPS_PRESS_DB = 3'b001,
		KPS_SCAN     = 3'b011,
		KPS_WAIT_REL = 3'b010,
		KPS_REL_DB   = 3'b110
	} kps_state_t;
endpackage : kps_pkg

//--- kps_scanner.sv
// keypad matrix scanner: idle detect, debounce, column walk, release
// Contract
// R1 - serve 30 keys: 5 drives, 6 senses
// R2 - low column plus low sense means closed
// R3 - hardware scanning off until firmware enables it
// R4 - valid key pulses event, loads position registers
// R5 - all timing from the outside 1 kHz tick
// R6 - run only while keypad clock enable set
// R7 - active rows and columns set by size
// R8 - idle drives all columns low, waits
// R9 - recheck press after debounce, else idle
// R10 - debounce 4 ms to 256 ms, 4 ms steps
// R11 - one column low, advance after all senses
// R12 - check spacing 1 to 4 ms, two bits
// R13 - cover whole keypad, order keeps interval
// R14 - report only when exactly one key closed
// R15 - column order from order words, rows fixed
// R16 - enabled: position registers change on valid only
// R17 - continue without waiting for event service
// R18 - after detection wait for key release
// R19 - release starts debounce, restart if pressed
// R20 - confirmed release: all low, wait again
// R21 - disabled: drives follow the column register
// R22 - firmware scans manually with scanning cleared
// R23 - column bits 4:0, cleared bit drives low
// R24 - row bits 5:0, cleared bit reads low
// R25 - debounce units 4 ms, zero means 256
// R26 - timers count 1 kHz ticks
`timescale 1ns/100ps
`default_nettype none
module kps_scanner
	import kps_pkg::*;
#(
	parameter int COLS = kps_pkg::KPS_NUM_COLS,
	parameter int ROWS = kps_pkg::KPS_NUM_ROWS
) (
	input  wire logic              core_clk_i,
	input  wire logic              srst_i,
	input  wire logic              tick_1khz_i,
	input  wire logic              keypad_clock_enable_i,
	input  wire logic              hw_scan_enable_i,
	input  wire logic [5:0]        debounce_interval_i,
	input  wire logic [1:0]        scan_interval_i,
	input  wire logic [7:0]        scan_order_low_i,
	input  wire logic [7:0]        scan_order_high_i,
	input  wire logic [7:0]        matrix_size_i,
	input  wire logic              drive_wr_i,
	input  wire logic [COLS-1:0]   drive_wdata_i,
	input  wire logic [ROWS-1:0]   sense_i,
	output logic      [COLS-1:0]   drive_o,
	output logic      [COLS-1:0]   detected_drive_reg_o,
	output logic      [ROWS-1:0]   detected_sense_reg_o,
	output logic                   key_event_o,
	output logic                   scan_busy_o
);
	import kps_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// column number held in a scan order slot
	function automatic logic [2:0] slot_col(input logic [2:0] slot,
		input logic [15:0] order);
		logic [15:0] sh;
		sh = order >> (slot * KPS_SLOT_W);
		slot_col = sh[2:0];
	endfunction : slot_col

	// pattern with a single low drive line
	function automatic logic [COLS-1:0] low_one(input logic [2:0] c);
		low_one = ~(COLS'(1) << c);
	endfunction : low_one

	// count of active lines, zero or too large selects all
	function automatic logic [2:0] active_cnt(input logic [2:0] v,
		input logic [2:0] max);
		active_cnt = (v == 3'h0 || v > max) ? max : v;
	endfunction : active_cnt

	// ----------------------------------------------------------------
	// sense input synchroniser
	// ----------------------------------------------------------------
	// R1 six sense lines, five drive lines
	logic [ROWS-1:0] sense_s1;
	logic [ROWS-1:0] sense_s2;
	logic [ROWS-1:0] sense_s3;
	logic [ROWS-1:0] sense_q;
	logic [ROWS-1:0] next_sense_q;

	always_comb begin
		// a line counts as changed only once stages two and three agree
		for (int i = 0; i < ROWS; i++) begin
			next_sense_q[i] = (sense_s2[i] == sense_s3[i]) ?
				sense_s3[i] : sense_q[i];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			sense_s1 <= '1;
			sense_s2 <= '1;
			sense_s3 <= '1;
			sense_q  <= '1;
		end else begin
			sense_s1 <= sense_i;
			sense_s2 <= sense_s1;
			sense_s3 <= sense_s2;
			sense_q  <= next_sense_q;
		end
	end

	// ----------------------------------------------------------------
	// derived configuration
	// ----------------------------------------------------------------
	logic [2:0]      n_cols;
	logic [2:0]      n_rows;
	logic [ROWS-1:0] row_mask;
	logic [ROWS-1:0] sense_low;
	logic            any_low;
	logic            tick;
	logic [8:0]      db_ticks;
	logic [8:0]      sc_ticks;
	logic [15:0]     order;

	// R7 size gating
	assign n_cols = active_cnt(matrix_size_i[KPS_SIZE_COLS_LSB +: 3],
		3'(COLS));
	assign n_rows = active_cnt(matrix_size_i[KPS_SIZE_ROWS_LSB +: 3],
		3'(ROWS));
	assign order = {scan_order_high_i, scan_order_low_i};

	always_comb begin
		for (int i = 0; i < ROWS; i++) begin
			row_mask[i] = (3'(i) < n_rows);
		end
	end

	// R2 low sense marks a closed switch
	assign sense_low = ~sense_q & row_mask;
	assign any_low   = |sense_low;

	// R5 R6 R26 timers advance only on enabled 1 kHz ticks
	assign tick = tick_1khz_i & keypad_clock_enable_i;

	// R10 R25 debounce in 4 ms units, zero means 256 ms
	assign db_ticks = ((debounce_interval_i == 6'h00) ? KPS_DB_ZERO_UNITS
		: {3'h0, debounce_interval_i}) * KPS_DB_STEP_MS;

	// R12 scan spacing in ms, zero means 4 ms
	assign sc_ticks = (scan_interval_i == 2'h0) ? KPS_SCAN_ZERO_MS
		: {7'h00, scan_interval_i};

	// ----------------------------------------------------------------
	// scanner state machine and registers
	// ----------------------------------------------------------------
	kps_state_t      state;
	kps_state_t      next_state;
	logic [8:0]      timer;
	logic [8:0]      next_timer;
	logic [2:0]      col_slot;
	logic [2:0]      next_col_slot;
	logic [2:0]      row_idx;
	logic [2:0]      next_row_idx;
	logic [1:0]      hits;
	logic [1:0]      next_hits;
	logic [1:0]      hits_now;
	logic [2:0]      hit_col;
	logic [2:0]      next_hit_col;
	logic [2:0]      hit_row;
	logic [2:0]      next_hit_row;
	logic [COLS-1:0] col_reg;
	logic [COLS-1:0] next_col_reg;
	logic [ROWS-1:0] row_reg;
	logic [ROWS-1:0] next_row_reg;
	logic [COLS-1:0] next_drive;
	logic            next_event;
	logic            hit;

	always_comb begin
		next_state    = state;
		next_timer    = timer;
		next_col_slot = col_slot;
		next_row_idx  = row_idx;
		next_hits     = hits;
		next_hit_col  = hit_col;
		next_hit_row  = hit_row;
		next_col_reg  = col_reg;
		next_row_reg  = row_reg;
		next_event    = 1'b0;
		hit           = sense_low[row_idx];
		hits_now      = (hit && hits != 2'h2) ? hits + 2'h1 : hits;
		if (!hw_scan_enable_i) begin
			// R3 R22 bypass: firmware owns columns, rows read live
			next_state = KPS_IDLE;
			if (drive_wr_i) begin
				next_col_reg = drive_wdata_i;
			end
			// R24 live sense level, cleared bit is a low line
			next_row_reg = sense_q;
		end else if (tick) begin
			case (state)
				// R8 wait with all columns low
				KPS_IDLE: begin
					if (any_low) begin
						next_state = KPS_PRESS_DB;
						next_timer = db_ticks;
					end
				end
				// R9 recheck after debounce
				KPS_PRESS_DB: begin
					if (timer > 9'h001) begin
						next_timer = timer - 9'h001;
					end else if (any_low) begin
						next_state    = KPS_SCAN;
						next_timer    = sc_ticks;
						next_col_slot = 3'h0;
						next_row_idx  = 3'h0;
						next_hits     = 2'h0;
					end else begin
						next_state = KPS_IDLE;
					end
				end
				// R11 R13 check one sense per interval
				KPS_SCAN: begin
					if (timer > 9'h001) begin
						next_timer = timer - 9'h001;
					end else begin
						next_timer = sc_ticks;
						next_hits  = hits_now;
						if (hit) begin
							next_hit_col = slot_col(col_slot, order);
							next_hit_row = row_idx;
						end
						if (row_idx + 3'h1 < n_rows) begin
							next_row_idx = row_idx + 3'h1;
						end else if (col_slot + 3'h1 < n_cols) begin
							next_row_idx  = 3'h0;
							next_col_slot = col_slot + 3'h1;
						end else begin
							// R17 R18 go on to release wait at once
							next_state = KPS_WAIT_REL;
							// R14 R16 single closure only
							if (hits_now == 2'h1) begin
								// R4 load position, pulse event
								next_event   = 1'b1;
								next_col_reg = hit ?
									low_one(slot_col(col_slot, order))
									: low_one(hit_col);
								next_row_reg = hit ?
									~(ROWS'(1) << row_idx)
									: ~(ROWS'(1) << hit_row);
							end
						end
					end
				end
				// R18 wait for every active sense line high
				KPS_WAIT_REL: begin
					if (!any_low) begin
						next_state = KPS_REL_DB;
						next_timer = db_ticks;
					end
				end
				// R19 R20 debounce release, restart if pressed
				KPS_REL_DB: begin
					if (timer > 9'h001) begin
						next_timer = timer - 9'h001;
					end else if (any_low) begin
						next_timer = db_ticks;
					end else begin
						next_state = KPS_IDLE;
					end
				end
				default: begin
					next_state = KPS_IDLE;
				end
			endcase
		end
		// R21 R23 drive lines; a cleared bit pulls its column low
		if (!hw_scan_enable_i) begin
			next_drive = next_col_reg;
		end else if (next_state == KPS_SCAN) begin
			// R15 column order from the order words
			next_drive = low_one(slot_col(next_col_slot, order));
		end else begin
			next_drive = '0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state       <= KPS_IDLE;
			timer       <= '0;
			col_slot    <= '0;
			row_idx     <= '0;
			hits        <= '0;
			hit_col     <= KPS_ORDER_RESET;
			hit_row     <= '0;
			col_reg     <= KPS_COL_RESET;
			row_reg     <= KPS_ROW_RESET;
			drive_o     <= KPS_COL_RESET;
			key_event_o <= 1'b0;
		end else begin
			state       <= next_state;
			timer       <= next_timer;
			col_slot    <= next_col_slot;
			row_idx     <= next_row_idx;
			hits        <= next_hits;
			hit_col     <= next_hit_col;
			hit_row     <= next_hit_row;
			col_reg     <= next_col_reg;
			row_reg     <= next_row_reg;
			drive_o     <= next_drive;
			key_event_o <= next_event;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign detected_drive_reg_o = col_reg;
	assign detected_sense_reg_o = row_reg;
	assign scan_busy_o          = hw_scan_enable_i && state != KPS_IDLE;

endmodule : kps_scanner
`default_nettype wire

//--- kps_keymat.sv
// switch matrix model: a closed key joins its column to its row
`timescale 1ns/100ps
`default_nettype none
module kps_keymat (
	input  wire logic [4:0]  drive_i,
	input  wire logic [29:0] key_i,
	output logic      [5:0]  sense_o
);
	always_comb begin
		sense_o = 6'h3f;
		for (int k = 0; k < 30; k++)
			if (key_i[k] && !drive_i[k / 6])
				sense_o[k % 6] = 1'b0;
	end
endmodule : kps_keymat
`default_nettype wire

//--- kps_scanner_monitor.sv
// port assertions for the keypad scanner
`timescale 1ns/100ps
`default_nettype none
module kps_scanner_monitor #(
	parameter int COLS = 5,
	parameter int ROWS = 6
) (
	input wire logic            core_clk_i,
	input wire logic            srst_i,
	input wire logic            tick_1khz_i,
	input wire logic            keypad_clock_enable_i,
	input wire logic            hw_scan_enable_i,
	input wire logic            drive_wr_i,
	input wire logic [COLS-1:0] drive_wdata_i,
	input wire logic [COLS-1:0] drive_o,
	input wire logic [COLS-1:0] detected_drive_reg_o,
	input wire logic [ROWS-1:0] detected_sense_reg_o,
	input wire logic            key_event_o,
	input wire logic            scan_busy_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);
	logic go;
	assign go = tick_1khz_i && keypad_clock_enable_i;
	ev_pulse_a: assert property (key_event_o |=> !key_event_o)
		else $error("event too long");
	one_key_a: assert property (key_event_o |->
		$onehot(~detected_drive_reg_o) && $onehot(~detected_sense_reg_o))
		else $error("event without one key");
	ev_tick_a: assert property (key_event_o |->
		$past(go) && $past(hw_scan_enable_i))
		else $error("event off tick");
	hold_pos_a: assert property (!key_event_o &&
		$past(hw_scan_enable_i) && !$past(srst_i) |->
		$stable(detected_drive_reg_o) && $stable(detected_sense_reg_o))
		else $error("position moved");
	bypass_drive_a: assert property (!$past(hw_scan_enable_i) &&
		!$past(srst_i) |-> drive_o == detected_drive_reg_o)
		else $error("bypass drive wrong");
	write_take_a: assert property (drive_wr_i && !hw_scan_enable_i |=>
		detected_drive_reg_o == $past(drive_wdata_i))
		else $error("write lost");
	tick_only_a: assert property ($past(hw_scan_enable_i, 2) &&
		$past(hw_scan_enable_i) && !$past(srst_i) && !$past(srst_i, 2)
		&& !$past(go) |-> $stable(drive_o))
		else $error("drive moved off tick");
	idle_low_a: assert property (hw_scan_enable_i && !scan_busy_o &&
		$past(hw_scan_enable_i) && !$past(srst_i) |-> drive_o == '0)
		else $error("idle drive not low");
	off_idle_a: assert property (!$past(hw_scan_enable_i) &&
		!$past(srst_i) && hw_scan_enable_i |-> !scan_busy_o)
		else $error("busy while off");
endmodule : kps_scanner_monitor
bind kps_scanner kps_scanner_monitor #(.COLS(COLS), .ROWS(ROWS)) mon (
	.core_clk_i(core_clk_i), .srst_i(srst_i), .tick_1khz_i(tick_1khz_i),
	.keypad_clock_enable_i(keypad_clock_enable_i),
	.hw_scan_enable_i(hw_scan_enable_i), .drive_wr_i(drive_wr_i),
	.drive_wdata_i(drive_wdata_i), .drive_o(drive_o),
	.detected_drive_reg_o(detected_drive_reg_o),
	.detected_sense_reg_o(detected_sense_reg_o),
	.key_event_o(key_event_o), .scan_busy_o(scan_busy_o));
`default_nettype wire

//--- testbench.sv
// self-checking bench: scanner against a switch matrix
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
	error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
	logic        clk = 1'b0, srst = 1'b1, tick = 1'b0, kce = 1'b0;
	logic        hwen = 1'b0, wr = 1'b0, pb = 1'b0, ev, busy;
	logic [4:0]  wd = 5'h1f, drv, dcol;
	logic [5:0]  dbu = 6'h01, sense, drow;
	logic [1:0]  sct = 2'h1;
	logic [15:0] ord = 16'h4688;
	logic [7:0]  msz = 8'h00;
	logic [29:0] keys = '0, kk;
	logic [31:0] rs = 32'h0000_0048;
	int          error_cnt = 0, samples_checked = 0, idx;
	int          cyc = 0, nt = 0, nev = 0, t0 = 0, te = 0;
	logic [15:0] ords [3] = '{16'h4688, 16'h029c, 16'h3302};
	always #20 clk = ~clk;
	kps_scanner uut (.core_clk_i(clk), .srst_i(srst), .tick_1khz_i(tick),
		.keypad_clock_enable_i(kce), .hw_scan_enable_i(hwen),
		.debounce_interval_i(dbu), .scan_interval_i(sct),
		.scan_order_low_i(ord[7:0]), .scan_order_high_i(ord[15:8]),
		.matrix_size_i(msz), .drive_wr_i(wr), .drive_wdata_i(wd),
		.sense_i(sense), .drive_o(drv), .detected_drive_reg_o(dcol),
		.detected_sense_reg_o(drow), .key_event_o(ev), .scan_busy_o(busy));
	kps_keymat mat (.drive_i(drv), .key_i(keys), .sense_o(sense));
	// tick every 8 cycles: short runs, yet the sense sync settles first
	always @(posedge clk) begin
		cyc++;
		tick <= (cyc % 8 == 0);
		if (tick && kce)
			nt++;
		if (busy === 1'b1 && !pb)
			t0 = nt;
		pb = (busy === 1'b1);
		if (ev === 1'b1) begin
			nev++;
			te = nt;
		end
		if (cyc == 40000) begin
			error_cnt++;
			finish_test();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	// reference: one closed key inside the active area gives an event
	task automatic press(input logic [29:0] k);
		int nc, nr, n, hit, d, s, e0;
		logic [10:0] pp;
		logic [7:0]  cm;
		nc = (msz[2:0] == 0 || msz[2:0] > 5) ? 5 : msz[2:0];
		nr = (msz[6:4] == 0 || msz[6:4] > 6) ? 6 : msz[6:4];
		// active columns are those named by the first nc order slots
		cm = '0;
		for (int c = 0; c < nc; c++)
			cm[ord[3 * c +: 3]] = 1'b1;
		n = 0;
		hit = 0;
		for (int i = 0; i < 30; i++)
			if (k[i] && cm[i / 6] && i % 6 < nr) begin
				n++;
				hit = i;
			end
		d = (dbu == 0) ? 256 : dbu * 4;
		s = (sct == 0) ? 4 : sct;
		e0 = nev;
		pp = {dcol, drow};
		@(posedge clk) keys <= k;
		for (int i = 0; i < (d + s * 30) * 8 + 60 && nev == e0; i++)
			@(posedge clk);
		if (n == 1) begin
			`CHK(nev - e0, 1)
			`CHK(te - t0, d + s * nc * nr)
			`CHK(dcol, ~(5'h01 << (hit / 6)))
			`CHK(drow, ~(6'h01 << (hit % 6)))
		end else begin
			`CHK(nev, e0)
			`CHK({dcol, drow}, pp)
		end
		@(posedge clk) keys <= '0;
		for (int i = 0; i < (d + 2) * 8 + 40 && busy !== 1'b0; i++)
			@(posedge clk);
		`CHK(busy, 1'b0)
		`CHK(drv, 5'h00)
	endtask : press
	task automatic finish_test;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		// firmware scans by hand in bypass
		keys <= 30'h000_0100;
		@(posedge clk) wr <= 1'b1;
		wd <= 5'h1d;
		@(posedge clk) wr <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK(drv, 5'h1d)
		`CHK(drow, 6'h3b)
		keys <= 30'h000_0001;
		hwen <= 1'b1;
		wr <= 1'b1;
		wd <= 5'h0a;
		@(posedge clk) wr <= 1'b0;
		repeat (200) @(posedge clk);
		`CHK(busy, 1'b0)
		`CHK(dcol, 5'h1d)
		`CHK(drv, 5'h00)
		keys <= '0;
		kce <= 1'b1;
		for (int j = 0; j < 8; j++) begin
			rs = xs(rs);
			idx = (j == 6) ? 8 : int'(rs[12:8]) % 30;
			kk = 30'h000_0001 << idx;
			if (j == 5)
				kk |= 30'h000_0001 << ((idx + 7) % 30);
			@(posedge clk) dbu <= (j == 7) ? 6'h00 : 6'(rs[1:0]) + 6'h01;
			sct <= rs[3:2];
			ord <= ords[rs[5:4] % 3];
			msz <= (j == 6) ? 8'h32 : 8'h00;
			// let the new settings land before the reference reads them
			@(posedge clk);
			press(kk);
		end
		finish_test();
	end
endmodule : testbench
`default_nettype wire
